/* inc/brd_pkg.sv */
// Constants and APB register map for the programmable baud-rate divider.
package brd_pkg;
    localparam int SEL_W          = 5;
    localparam int TABLE_DEPTH    = 32;
    localparam int ENTRY_W        = 19;
    localparam int DIV_W          = 20;
    // Table entry holds divisor minus this offset, reaching 2**19+1
    localparam logic [DIV_W-1:0] DIV_OFFSET = 20'h00002;
    localparam logic [DIV_W-1:0] DIV_MIN    = 20'h00006;
    localparam int ONEX_HALF      = 8;
    localparam int CLK_PERIOD_NS  = 100;
    localparam int SWITCH_MAX_NS  = 3500;
    localparam int SWITCH_CYCLES  = SWITCH_MAX_NS / CLK_PERIOD_NS;
    // APB register map
    localparam logic [3:0] REG_CTRL    = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h4;
    localparam logic [3:0] REG_DIVISOR = 4'h8;
    localparam logic       CTRL_RESET  = 1'b1;
    localparam int ST_SEL_LSB  = 0;
    localparam int ST_B16_BIT  = 8;
    localparam int ST_B1_BIT   = 9;
    localparam int ST_EN_BIT   = 10;
    localparam int ST_STB_BIT  = 11;
endpackage : brd_pkg

/* rtl/brd_div_core.sv */
// Half-cycle divider core producing the 16X baud clock from reference ticks.
`timescale 1ns/1ps
module brd_div_core #(
    parameter bit DEFER_SWITCH = 1'b0
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_b,
    input  wire logic                    tick,
    input  wire logic [brd_pkg::DIV_W-1:0] divisor,
    input  wire logic                    restart,
    output logic                         clkOut,
    output logic [brd_pkg::DIV_W-1:0]    curDivisor
);
    localparam int W = brd_pkg::DIV_W;

    function automatic logic [W-1:0] high_len(input logic [W-1:0] d);
        high_len = W'((d + W'(1)) >> 1);
    endfunction : high_len

    function automatic logic [W-1:0] low_len(input logic [W-1:0] d);
        low_len = d >> 1;
    endfunction : low_len

    logic [W-1:0] phaseLeft;
    logic [W-1:0] next_div;
    logic         boundary;

    assign boundary = tick && (phaseLeft == '0);
    // Deferred build takes the new divisor only at a half-cycle end
    assign next_div = DEFER_SWITCH ? divisor : curDivisor;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            clkOut     <= 1'b1;
            curDivisor <= '0;
            phaseLeft  <= '0;
        end else if (restart) begin
            clkOut     <= 1'b1;
            curDivisor <= divisor;
            phaseLeft  <= high_len(divisor) - W'(1);
        end else if (boundary) begin
            clkOut     <= !clkOut;
            curDivisor <= next_div;
            // Odd divisor: high phase one tick longer
            phaseLeft  <= (clkOut ? low_len(next_div) : high_len(next_div)) - W'(1);
        end else if (tick) begin
            phaseLeft  <= phaseLeft - W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [W-1:0] phaseTicks;
    logic         phaseClean;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            phaseTicks <= '0;
            phaseClean <= 1'b0;
        end else if (restart) begin
            phaseTicks <= '0;
            phaseClean <= 1'b1;
        end else if (boundary) begin
            phaseTicks <= '0;
            phaseClean <= (curDivisor == next_div) && (curDivisor != '0);
        end else if (tick) begin
            phaseTicks <= phaseTicks + W'(1);
        end
    end

    phase_len_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (boundary && phaseClean && !restart) |->
        (phaseTicks + W'(1)) == (clkOut ? high_len(curDivisor) : low_len(curDivisor)))
        else $error("baud half-cycle length wrong");

    div_range_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (curDivisor != '0) |-> (curDivisor >= brd_pkg::DIV_MIN))
        else $error("divisor below minimum");

    defer_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (DEFER_SWITCH && !boundary) |=> (curDivisor == $past(curDivisor)))
        else $error("deferred divisor switched inside a half-cycle");
endmodule : brd_div_core

/* rtl/brd_baud_gen.sv */
// Top of the baud-rate divider: select latch, table, outputs and APB registers.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module brd_baud_gen #(
    parameter int REF_DIV      = 1,
    parameter bit DEFER_SWITCH = 1'b0,
    parameter logic [brd_pkg::TABLE_DEPTH*brd_pkg::ENTRY_W-1:0] DIV_TABLE =
        {brd_pkg::TABLE_DEPTH{19'h0000e}}
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [3:0]  selectNibble,
    input  wire logic        selectHigh,
    input  wire logic [4:0]  selectDriven,
    input  wire logic        select_strobe,
    input  wire logic        out_enable_n,
    input  wire logic        enableDriven,
    output logic             baud_clk_16x,
    output logic             baud_clk_1x,
    output logic             ref_clk_out,
    output logic             ref_clk_quarter
);
    localparam int SEL_W = brd_pkg::SEL_W;
    localparam int DIV_W = brd_pkg::DIV_W;
    localparam int ENT_W = brd_pkg::ENTRY_W;
    localparam int SwLim = brd_pkg::SWITCH_CYCLES;

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (REF_DIV < 1 || REF_DIV > brd_pkg::SWITCH_CYCLES) begin : g_bad_refdiv
        $error("REF_DIV must lie in 1..switch limit");
    end
    for (genvar i = 0; i < brd_pkg::TABLE_DEPTH; i++) begin : g_tab_chk
        if (DIV_TABLE[i*ENT_W +: ENT_W] < ENT_W'(brd_pkg::DIV_MIN - brd_pkg::DIV_OFFSET))
        begin : g_bad
            $error("divisor table entry below minimum");
        end
    end

    function automatic logic [DIV_W-1:0] table_lookup(input logic [SEL_W-1:0] idx);
        table_lookup = DIV_W'(DIV_TABLE[idx*ENT_W +: ENT_W]) + brd_pkg::DIV_OFFSET;
    endfunction : table_lookup

    ////////////////////////////////////////////////////////////////////////////////
    // Reference ticks and reference outputs
    logic [7:0] preCnt;
    logic       tick;
    logic [1:0] quarterCnt;

    assign tick = (preCnt == 8'(REF_DIV - 1));

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            preCnt <= '0;
        end else if (tick) begin
            preCnt <= '0;
        end else begin
            preCnt <= preCnt + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            quarterCnt      <= '0;
            ref_clk_out     <= 1'b0;
            ref_clk_quarter <= 1'b0;
        end else begin
            ref_clk_out <= tick;
            if (tick) begin
                quarterCnt      <= quarterCnt + 2'h1;
                ref_clk_quarter <= quarterCnt[0] ? !ref_clk_quarter : ref_clk_quarter;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pins with pull-ups, select latch
    logic [SEL_W-1:0] pinSel;
    logic [SEL_W-1:0] selLatch;
    logic [SEL_W-1:0] effSel;
    logic             pinEnable;

    // Undriven pins read high
    assign pinSel    = {selectHigh, selectNibble} | ~selectDriven;
    assign pinEnable = out_enable_n | !enableDriven;
    // Transparent while the strobe is high
    assign effSel    = select_strobe ? pinSel : selLatch;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            selLatch <= '1;
        end else if (select_strobe) begin
            selLatch <= pinSel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Divider
    logic [DIV_W-1:0] tableDiv;
    logic [DIV_W-1:0] curDivisor;
    logic             raw16;
    logic             restart;

    assign tableDiv = table_lookup(effSel);
    // Immediate switch restarts on any table change
    assign restart  = !DEFER_SWITCH && (tableDiv != curDivisor);

    brd_div_core #(
        .DEFER_SWITCH (DEFER_SWITCH)
    ) u_core (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .tick       (tick),
        .divisor    (tableDiv),
        .restart    (restart),
        .clkOut     (raw16),
        .curDivisor (curDivisor)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // 1X divider and gated outputs
    logic       raw16Prev;
    logic       raw1;
    logic [2:0] riseCnt;
    logic       rise16;
    logic       softEnable;
    logic       outEnable;

    assign rise16    = raw16 && !raw16Prev;
    assign outEnable = pinEnable && softEnable;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            raw16Prev <= 1'b1;
            raw1      <= 1'b1;
            riseCnt   <= '0;
        end else begin
            raw16Prev <= raw16;
            if (rise16) begin
                riseCnt <= riseCnt + 3'h1;
                // Toggle every eighth 16X rise
                if (riseCnt == 3'(brd_pkg::ONEX_HALF - 1)) begin
                    raw1 <= !raw1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            baud_clk_16x <= 1'b1;
            baud_clk_1x  <= 1'b1;
        end else begin
            baud_clk_16x <= outEnable ? raw16 : 1'b1;
            baud_clk_1x  <= outEnable ? raw1 : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic        setup;

    assign pready = 1'b1;
    assign setup  = psel && !penable;

    always_comb begin
        next_prdata  = '0;
        next_pslverr = 1'b0;
        if (paddr[31:4] != '0) begin
            next_pslverr = 1'b1;
        end else begin
            case (paddr[3:0])
                brd_pkg::REG_CTRL: begin
                    next_prdata[0] = softEnable;
                end
                brd_pkg::REG_STATUS: begin
                    next_prdata[brd_pkg::ST_SEL_LSB +: SEL_W] = effSel;
                    next_prdata[brd_pkg::ST_B16_BIT]          = baud_clk_16x;
                    next_prdata[brd_pkg::ST_B1_BIT]           = baud_clk_1x;
                    next_prdata[brd_pkg::ST_EN_BIT]           = outEnable;
                    next_prdata[brd_pkg::ST_STB_BIT]          = select_strobe;
                end
                brd_pkg::REG_DIVISOR: begin
                    next_prdata[DIV_W-1:0] = curDivisor;
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h00000000 : next_prdata;
            pslverr <= next_pslverr;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            softEnable <= brd_pkg::CTRL_RESET;
        end else if (psel && penable && pwrite && !pslverr
                     && paddr[3:0] == brd_pkg::REG_CTRL) begin
            softEnable <= pwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    logic [3:0] risesSince;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            risesSince <= '0;
        end else if (raw1 != $past(raw1)) begin
            risesSince <= '0;
        end else if (rise16) begin
            risesSince <= risesSince + 4'h1;
        end
    end

    sequence disabled_s;
        !outEnable;
    endsequence

    sequence held_high_s;
        baud_clk_16x && baud_clk_1x;
    endsequence

    out_hold_a: assert property (disabled_s |=> held_high_s)
        else $error("outputs not held high while disabled");

    open_enable_a: assert property (!enableDriven && softEnable |=>
        baud_clk_16x == $past(raw16))
        else $error("open enable pin did not enable outputs");

    latch_hold_a: assert property (!select_strobe |=> selLatch == $past(selLatch))
        else $error("select latch changed with strobe low");

    pass_through_a: assert property (select_strobe |->
        effSel == ({selectHigh, selectNibble} | ~selectDriven))
        else $error("select not passed through while strobe high");

    switch_time_a: assert property (!DEFER_SWITCH && $changed(tableDiv)
        |-> ##[1:SwLim] (curDivisor == tableDiv) || $changed(tableDiv))
        else $error("new divisor not taken in time");

    onex_toggle_a: assert property ($changed(raw1) |->
        $past(rise16) && $past(risesSince) == 4'(brd_pkg::ONEX_HALF - 1))
        else $error("1X clock toggled off the eighth 16X rise");

    quarter_step_a: assert property ($changed(ref_clk_quarter) |-> $past(tick))
        else $error("quarter reference moved without a reference tick");

    enable_run_a: assert property (outEnable ##1 outEnable |->
        baud_clk_16x == $past(raw16))
        else $error("16X output not following divider while enabled");
endmodule : brd_baud_gen

/* bench/brd_uart_sink.sv */
// Serial device model that consumes the baud clocks and measures their phases.
`timescale 1ns/1ps
module brd_uart_sink (
    input  wire logic   sys_clk,
    input  wire logic   baud_clk_16x,
    input  wire logic   baud_clk_1x,
    output logic        measValid,
    output logic [7:0]  hiLen,
    output logic [7:0]  loLen,
    output logic [15:0] halfLen
);
    logic [7:0]  hiCnt;
    logic [7:0]  loCnt;
    logic [15:0] halfCnt;
    logic        last16;
    logic        last1;
    initial begin
        {hiCnt, loCnt, halfCnt, hiLen, loLen, halfLen, measValid, last16, last1} = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // 16X phases in system clocks, reported at each rise
    always @(posedge sys_clk) begin
        measValid <= 1'b0;
        last16 <= baud_clk_16x;
        if (baud_clk_16x)
            hiCnt <= hiCnt + 8'h01;
        else
            loCnt <= loCnt + 8'h01;
        if (baud_clk_16x && !last16) begin
            hiLen <= hiCnt;
            loLen <= loCnt;
            measValid <= 1'b1;
            hiCnt <= 8'h01;
            loCnt <= 8'h00;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // 1X half-phase length
    always @(posedge sys_clk) begin
        last1 <= baud_clk_1x;
        halfCnt <= halfCnt + 16'h0001;
        if (baud_clk_1x != last1) begin
            halfLen <= halfCnt;
            halfCnt <= 16'h0001;
        end
    end
endmodule : brd_uart_sink

/* bench/brd_baud_gen_tb.sv */
// Self-checking testbench for the baud-rate divider.
`timescale 1ns/1ps
module brd_baud_gen_tb;
    function automatic logic [32*19-1:0] make_table();
        logic [32*19-1:0] t;
        for (int i = 0; i < 32; i++) t[i*19 +: 19] = 19'(i + 4);
        return t;
    endfunction : make_table
    localparam logic [32*19-1:0] TBL = make_table();
    logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, rdErr, lowSeen;
    logic [31:0] paddr, pwdata, prdata, rdata;
    logic [3:0]  selectNibble;
    logic [4:0]  selectDriven, drv;
    logic        selectHigh, select_strobe, out_enable_n, enableDriven, measValid;
    logic        baud_clk_16x, baud_clk_1x, ref_clk_out, ref_clk_quarter;
    logic        defer16, defer1;
    logic [7:0]  hiLen, loLen, hiLenD, loLenD;
    logic [15:0] halfLen, halfLenD;
    logic [2:0]  qHist;
    logic [31:0] expQ[$];
    int          fails, checks_done;

    brd_baud_gen #(.DIV_TABLE(TBL)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .selectNibble(selectNibble),
        .selectHigh(selectHigh), .selectDriven(selectDriven), .select_strobe(select_strobe),
        .out_enable_n(out_enable_n), .enableDriven(enableDriven),
        .baud_clk_16x(baud_clk_16x), .baud_clk_1x(baud_clk_1x),
        .ref_clk_out(ref_clk_out), .ref_clk_quarter(ref_clk_quarter));
    brd_uart_sink sink (.sys_clk(sys_clk), .baud_clk_16x(baud_clk_16x),
        .baud_clk_1x(baud_clk_1x), .measValid(measValid), .hiLen(hiLen),
        .loLen(loLen), .halfLen(halfLen));
    // Deferred-switch build on the same pins
    brd_baud_gen #(.DIV_TABLE(TBL), .DEFER_SWITCH(1'b1)) uutDefer (.sys_clk(sys_clk),
        .rst_b(rst_b), .psel(1'b0), .penable(1'b0), .pwrite(1'b0), .paddr(32'h0),
        .pwdata(32'h0), .pready(), .prdata(), .pslverr(), .selectNibble(selectNibble),
        .selectHigh(selectHigh), .selectDriven(selectDriven), .select_strobe(select_strobe),
        .out_enable_n(out_enable_n), .enableDriven(enableDriven),
        .baud_clk_16x(defer16), .baud_clk_1x(defer1), .ref_clk_out(), .ref_clk_quarter());
    brd_uart_sink sinkDefer (.sys_clk(sys_clk), .baud_clk_16x(defer16),
        .baud_clk_1x(defer1), .measValid(), .hiLen(hiLenD), .loLen(loLenD),
        .halfLen(halfLenD));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdata = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic reg_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                           input string name);
        apb(1'b0, a, 32'h0);
        chk(name, rdata & m, e);
    endtask : reg_chk
    task automatic drive_sel(input logic [4:0] v, input logic [4:0] dv, input logic stb);
        {selectHigh, selectNibble} <= v;
        selectDriven <= dv;
        select_strobe <= stb;
        @(posedge sys_clk);
    endtask : drive_sel
    // Register check after the switch bound, then one phase record
    task automatic expect_div(input int idx);
        int d;
        d = idx + 6;
        repeat (36) @(posedge sys_clk);
        reg_chk(32'h8, 32'h000fffff, 32'(d), "divisor");
        reg_chk(32'h4, 32'h1f, 32'(idx), "select");
        repeat (18 * d) @(posedge sys_clk);
        expQ.push_back({8'((d + 1) / 2), 8'(d / 2), 16'(8 * d)});
        while (expQ.size() > 0) @(posedge sys_clk);
        chk("deferred", {hiLenD, loLenD, halfLenD}, {8'((d + 1) / 2), 8'(d / 2), 16'(8 * d)});
    endtask : expect_div
    task automatic hold_high(input int n);
        repeat (3) @(posedge sys_clk);
        repeat (n) begin
            @(posedge sys_clk);
            chk("held", {baud_clk_16x, baud_clk_1x}, 2'b11);
        end
    endtask : hold_high
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        fails++;
        end_sim();
    end
    always @(posedge sys_clk) begin
        if (measValid && expQ.size() > 0)
            chk("phases", {hiLen, loLen, halfLen}, expQ.pop_front());
    end
    initial begin
        void'($urandom(28407));
        {rst_b, psel, penable, pwrite, paddr, pwdata, selectHigh, selectNibble} = '0;
        {select_strobe, selectDriven, out_enable_n, enableDriven} = 8'h3f;
        select_strobe = 1'b0;
        repeat (10) @(posedge sys_clk);
        chk("reset", {baud_clk_16x, baud_clk_1x}, 2'b11);
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        reg_chk(32'h0, 32'h1, 32'h1, "ctrl");
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            qHist = {qHist[1:0], ref_clk_quarter};
            chk("ref", ref_clk_out, 1'b1);
            if (i >= 2)
                chk("quarter", qHist[0], !qHist[2]);
        end
        expect_div(31);
        for (int i = 0; i < 32; i++) begin
            drv = 5'($urandom) | ~5'(i);
            drive_sel(5'(i) & drv, drv, 1'b1);
            expect_div(i);
        end
        drive_sel(5'($urandom) & 5'h0f, 5'h1f, 1'b0);
        expect_div(31);
        out_enable_n <= 1'b0;
        hold_high(40);
        enableDriven <= 1'b0;
        lowSeen = 1'b0;
        repeat (80) begin
            @(posedge sys_clk);
            if (baud_clk_16x === 1'b0)
                lowSeen = 1'b1;
        end
        chk("open enable", lowSeen, 1'b1);
        enableDriven <= 1'b1;
        out_enable_n <= 1'b1;
        apb(1'b1, 32'h0, 32'h0);
        hold_high(40);
        apb(1'b1, 32'h0, 32'h1);
        apb(1'b0, 32'h10, 32'h0);
        chk("unmapped err", rdErr, 1'b1);
        chk("unmapped data", rdata, 32'h0);
        apb(1'b1, 32'h8, 32'h3);
        expect_div(31);
        end_sim();
    end
endmodule : brd_baud_gen_tb
